// ===== design/pqpc_map.svh
`ifndef PQPC_MAP_SVH
`define PQPC_MAP_SVH
// Overview of operation
// [R1] Noise-floor reply carries 4-bit level index, 50 dBuV base, 3 dB steps.
// [R2] Controller sends the three queries without parameters, only when needed.
// [R3] Every query answer is a reply to the access side, only after its query.
// [R4] Signal quality reply carries 3-bit index, 0 dB base, 3 dB steps.
// [R5] Quality comes from signal minus noise of last frame, held until next frame.
// [R6] Mains crossing reply carries time stamp of the latest crossing event.
// [R7] Times count in 10 us units on a free-running 20-bit time base.
// [R8] Management requests are optional and may be left out as a group.
// [R9] Reinit returns state machines to start and empties all buffers.
// [R10] Reinit reply result is 0 on success, 1 on internal failure.
// [R11] Suspend lets pending transmission finish, then stops all activity.
// [R12] Suspend reply result is 0 success, 1 failure, 2 already asleep.
// [R13] Wake leaves suspended state and restarts transmit and receive.
// [R14] Wake reply result is 0 success, 1 failure, 2 already running.
// [R15] Wake is issued only after a prior suspend request.
// [R16] One-cycle request pulse with code; one outstanding until one-cycle reply.

// Request codes
`define PQPC_CMD_FLOOR    3'h1
`define PQPC_CMD_QUALITY  3'h2
`define PQPC_CMD_CROSSING 3'h3
`define PQPC_CMD_REINIT   3'h4
`define PQPC_CMD_SUSPEND  3'h5
`define PQPC_CMD_WAKE     3'h6

// Result codes
`define PQPC_RES_OK       2'h0
`define PQPC_RES_FAIL     2'h1
`define PQPC_RES_ALREADY  2'h2

// Level coding
`define PQPC_FLOOR_BASE   8'h32
`define PQPC_QUAL_BASE    8'h00
`define PQPC_STEP_DB      8'h03

// Time base
`define PQPC_TICK_NS      10000
`define PQPC_CLK_NS       25
`define PQPC_TICK_CYC     (`PQPC_TICK_NS / `PQPC_CLK_NS)

// Register offsets (byte addresses)
`define PQPC_REG_CTRL     4'h0
`define PQPC_REG_STATUS   4'h4
`define PQPC_REG_CROSS    4'h8
`define PQPC_REG_TIME     4'hC
`define PQPC_CTRL_MGMT    0
`define PQPC_CTRL_RESET   1'h1
`endif

// ===== design/pqpc_pkg.sv
package pqpc_pkg;
  // Power mode of the physical layer
  typedef enum logic [1:0]
  {
    PQPC_RUN   = 2'b00,
    PQPC_DRAIN = 2'b01,
    PQPC_SLEEP = 2'b10
  } pqpc_mode_e;

  // Whole block state
  typedef struct packed
  {
    pqpc_mode_e  mode;
    logic [8:0]  tick_cnt;
    logic [19:0] now;
    logic [19:0] cross_time;
    logic [2:0]  qual_idx;
    logic        rsp_valid;
    logic [2:0]  rsp_code;
    logic [1:0]  rsp_result;
    logic [19:0] rsp_data;
    logic        flush;
    logic        mgmt_en;
    logic        bus_ack;
    logic [31:0] readdata;
  } pqpc_state_s;
endpackage

// ===== design/pqpc_top.sv
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`include "pqpc_map.svh"

module pqpc_top
#(
  parameter bit MGMT_PRESENT = 1'b1
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Request side
  input  wire logic        req_valid_i,
  input  wire logic [2:0]  req_code_i,
  output logic             rsp_valid_o,
  output logic [2:0]       rsp_code_o,
  output logic [1:0]       rsp_result_o,
  output logic [19:0]      rsp_data_o,
  // Measurement side
  input  wire logic [7:0]  noise_level_i,
  input  wire logic        frame_done_i,
  input  wire logic [7:0]  frame_signal_i,
  input  wire logic [7:0]  frame_noise_i,
  input  wire logic        mains_cross_i,
  input  wire logic        tx_busy_i,
  input  wire logic        core_fault_i,
  output logic             rx_enable_o,
  output logic             tx_enable_o,
  output logic             flush_o,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  // Whole block state and its next value
  pqpc_pkg::pqpc_state_s st;
  pqpc_pkg::pqpc_state_s next_st;

  // Threshold coding: index counts steps above base, saturating
  // Equal to a threshold still gives the lower index
  function automatic logic [3:0] level_code
  (
    input logic [8:0] level,
    input logic [7:0] base,
    input logic [3:0] top
  );
    logic [3:0] idx;
    logic [8:0] edge_v;
    idx = 4'h0;
    for (int i = 0; i < 15; i++)
    begin
      edge_v = {1'b0, base} + 9'(i * 3);
      if ((4'(i) < top) && (level > edge_v))
      begin
        idx = 4'(i + 1);
      end
    end
    return idx;
  endfunction

  // Management requests fail when the group is off or the core reports trouble
  function automatic logic mgmt_refused
  (
    input logic ok,
    input logic fault
  );
    return !ok || fault;
  endfunction

  // Decoded levels and helper terms
  logic [8:0] qual_db;
  logic [3:0] floor_idx;
  logic [3:0] qual_code;
  logic       rx_on;
  logic       bus_req;
  logic       mgmt_ok;

  // Quality in dB, clamped at zero when noise exceeds signal
  assign qual_db = (frame_signal_i > frame_noise_i)
                   ? 9'(frame_signal_i - frame_noise_i)
                   : 9'h000;
  assign qual_code = level_code(qual_db, `PQPC_QUAL_BASE, 4'h7); // R4
  assign floor_idx = level_code({1'b0, noise_level_i}, `PQPC_FLOOR_BASE, 4'hF); // R1

  // Power mode and bus request terms
  assign rx_on     = (st.mode == pqpc_pkg::PQPC_RUN);
  assign bus_req   = avs_read | avs_write;
  assign mgmt_ok   = MGMT_PRESENT & st.mgmt_en; // R8

  // Next state
  always_comb
  begin
    // Strobes default low, everything else holds
    next_st = st;
    next_st.rsp_valid = 1'b0;
    next_st.flush = 1'b0;
    next_st.bus_ack = 1'b0;

    // Free-running 10 us time base
    // The time stamp wraps after 2^20 ticks
    if (st.tick_cnt == 9'(`PQPC_TICK_CYC - 1)) // R7
    begin
      next_st.tick_cnt = 9'h000;
      next_st.now = st.now + 20'h00001;
    end
    else
    begin
      next_st.tick_cnt = st.tick_cnt + 9'h001;
    end

    // Latch time of latest mains crossing
    if (mains_cross_i)
    begin
      next_st.cross_time = st.now; // R6
    end

    // Keep quality of the last received frame
    // Frames seen while draining or asleep are dropped
    if (frame_done_i && rx_on)
    begin
      next_st.qual_idx = qual_code[2:0]; // R5
    end

    // Drain finished: enter sleep and answer
    // The suspend reply waits here until the transmitter is idle
    if ((st.mode == pqpc_pkg::PQPC_DRAIN) && !tx_busy_i)
    begin
      next_st.mode = pqpc_pkg::PQPC_SLEEP; // R11
      next_st.rsp_valid = 1'b1;
      next_st.rsp_code = `PQPC_CMD_SUSPEND;
      next_st.rsp_result = `PQPC_RES_OK; // R12
      next_st.rsp_data = 20'h00000;
    end

    // Request decode
    // Every reply echoes its code; queries always succeed
    if (req_valid_i) // R16
    begin
      next_st.rsp_code = req_code_i;
      next_st.rsp_data = 20'h00000;
      next_st.rsp_result = `PQPC_RES_OK;
      next_st.rsp_valid = 1'b1;
      case (req_code_i)
        // Floor index coded live from the present noise level
        `PQPC_CMD_FLOOR:
        begin
          next_st.rsp_data = {16'h0000, floor_idx}; // R1 R3
        end
        // Quality index of the last frame
        `PQPC_CMD_QUALITY:
        begin
          next_st.rsp_data = {17'h00000, st.qual_idx}; // R4 R3
        end
        // Time stamp of the latest crossing
        `PQPC_CMD_CROSSING:
        begin
          next_st.rsp_data = st.cross_time; // R6 R3
        end
        // Reinit: back to run, drop quality, pulse flush
        `PQPC_CMD_REINIT:
        begin
          if (mgmt_refused(mgmt_ok, core_fault_i))
          begin
            next_st.rsp_result = `PQPC_RES_FAIL; // R10
          end
          else
          begin
            next_st.mode = pqpc_pkg::PQPC_RUN; // R9
            next_st.qual_idx = 3'h0;
            next_st.flush = 1'b1;
          end
        end
        // Suspend: already asleep, refused, or start draining
        `PQPC_CMD_SUSPEND:
        begin
          if (st.mode == pqpc_pkg::PQPC_SLEEP)
          begin
            next_st.rsp_result = `PQPC_RES_ALREADY; // R12
          end
          else if (mgmt_refused(mgmt_ok, core_fault_i))
          begin
            next_st.rsp_result = `PQPC_RES_FAIL; // R12
          end
          else
          begin
            // Reply deferred until transmission drains
            next_st.mode = pqpc_pkg::PQPC_DRAIN; // R11
            next_st.rsp_valid = 1'b0;
          end
        end
        // Wake: already running, refused, or back to run
        `PQPC_CMD_WAKE:
        begin
          if (st.mode == pqpc_pkg::PQPC_RUN)
          begin
            next_st.rsp_result = `PQPC_RES_ALREADY; // R14
          end
          else if (mgmt_refused(mgmt_ok, core_fault_i))
          begin
            next_st.rsp_result = `PQPC_RES_FAIL; // R14
          end
          else
          begin
            next_st.mode = pqpc_pkg::PQPC_RUN; // R13
          end
        end
        // Unknown codes are answered with a failure
        default:
        begin
          next_st.rsp_result = `PQPC_RES_FAIL;
        end
      endcase
    end

    // Register access: first cycle builds read data, second completes
    // Read data stands from the wait-state edge until the wait-state edge of the next read
    if (bus_req && !st.bus_ack)
    begin
      next_st.bus_ack = 1'b1;
      // Reads latch the addressed word for the wait-state cycle
      if (avs_read)
      begin
        case (avs_address)
          // Management enable
          `PQPC_REG_CTRL:
          begin
            next_st.readdata = {31'h00000000, st.mgmt_en};
          end
          // Mode, pending transmit, floor and quality
          `PQPC_REG_STATUS:
          begin
            next_st.readdata = {22'h000000, st.qual_idx, floor_idx,
                                tx_busy_i, st.mode};
          end
          // Latest crossing time
          `PQPC_REG_CROSS:
          begin
            next_st.readdata = {12'h000, st.cross_time};
          end
          // Current time
          `PQPC_REG_TIME:
          begin
            next_st.readdata = {12'h000, st.now};
          end
          // Unmapped offsets read as zero
          default:
          begin
            next_st.readdata = 32'h00000000;
          end
        endcase
      end
    end

    // Write lands only on the edge where waitrequest is seen low
    if (avs_write && st.bus_ack && (avs_address == `PQPC_REG_CTRL))
    begin
      next_st.mgmt_en = avs_writedata[`PQPC_CTRL_MGMT]; // R8
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      // Power mode, time base and measurements
      st.mode       <= pqpc_pkg::PQPC_RUN;
      st.tick_cnt   <= 9'h000;
      st.now        <= 20'h00000;
      st.cross_time <= 20'h00000;
      st.qual_idx   <= 3'h0;
      // Reply registers
      st.rsp_valid  <= 1'b0;
      st.rsp_code   <= 3'h0;
      st.rsp_result <= 2'h0;
      st.rsp_data   <= 20'h00000;
      // Control and bus
      st.flush      <= 1'b0;
      st.mgmt_en    <= `PQPC_CTRL_RESET;
      st.bus_ack    <= 1'b0;
      st.readdata   <= 32'h00000000;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Reply outputs
  assign rsp_valid_o     = st.rsp_valid;
  assign rsp_code_o      = st.rsp_code;
  assign rsp_result_o    = st.rsp_result;
  assign rsp_data_o      = st.rsp_data;

  // Power control outputs
  assign flush_o         = st.flush; // R9
  assign rx_enable_o     = rx_on; // R11 R13
  assign tx_enable_o     = (st.mode != pqpc_pkg::PQPC_SLEEP); // R11 R13

  // Bus outputs
  assign avs_readdata    = st.readdata;
  assign avs_waitrequest = bus_req & ~st.bus_ack;

endmodule

// ===== dv/pqpc_mac_model.sv
module pqpc_mac_model
(
  input  wire logic        clk_i,
  output logic             req_valid_o,
  output logic [2:0]       req_code_o,
  input  wire logic        rsp_valid_i,
  input  wire logic [1:0]  rsp_result_i,
  input  wire logic [19:0] rsp_data_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req_valid_o = 1'b0;
  initial req_code_o = 3'h0;
  // One request, then wait for its one-cycle reply
  // Reply is taken at the rising edge where its strobe is seen high
  task automatic send(input logic [2:0] c, output logic [1:0] res, output logic [19:0] dat);
    req_valid_o <= 1'b1;
    req_code_o <= c;
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    req_code_o <= ~c;
    do
    begin
      @(posedge clk_i);
    end
    while (rsp_valid_i !== 1'b1);
    res = rsp_result_i;
    dat = rsp_data_i;
  endtask
endmodule

// ===== dv/pqpc_top_sva.sv
module pqpc_top_sva
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        req_valid_i,
  input wire logic [2:0]  req_code_i,
  input wire logic        rsp_valid_o,
  input wire logic [2:0]  rsp_code_o,
  input wire logic [1:0]  rsp_result_o,
  input wire logic [19:0] rsp_data_o,
  input wire logic [7:0]  noise_level_i,
  input wire logic        tx_busy_i,
  input wire logic        core_fault_i,
  input wire logic        rx_enable_o,
  input wire logic        tx_enable_o,
  input wire logic        flush_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Reply timing and pairing with requests
  property p_qry; req_valid_i && req_code_i inside {3'h1, 3'h2, 3'h3}
    |=> rsp_valid_o && rsp_code_o == $past(req_code_i); endproperty
  a_qry: assert property (p_qry) else $error("query reply missing");
  property p_pulse; rsp_valid_o |=> !rsp_valid_o; endproperty
  a_pulse: assert property (p_pulse) else $error("reply too long");
  property p_cause; rsp_valid_o && rsp_code_o != 3'h5 |-> $past(req_valid_i); endproperty
  a_cause: assert property (p_cause) else $error("reply without request");
  // Payload and power mode checks
  property p_top; req_valid_i && req_code_i == 3'h1 && noise_level_i > 8'h5C
    |=> rsp_data_o == 20'h0000F; endproperty
  a_top: assert property (p_top) else $error("floor top index");
  property p_slp; rsp_valid_o && rsp_code_o == 3'h5 && rsp_result_o == 2'h0
    |-> !rx_enable_o && !tx_enable_o && $past(!tx_busy_i); endproperty
  a_slp: assert property (p_slp) else $error("suspend state");
  property p_wake; rsp_valid_o && rsp_code_o == 3'h6 && rsp_result_o == 2'h0
    |-> rx_enable_o && tx_enable_o; endproperty
  a_wake: assert property (p_wake) else $error("wake state");
  property p_flush; flush_o |-> $past(req_valid_i && req_code_i == 3'h4); endproperty
  a_flush: assert property (p_flush) else $error("stray flush");
  property p_fault; req_valid_i && req_code_i == 3'h4 && core_fault_i
    |=> rsp_result_o == 2'h1 && !flush_o; endproperty
  a_fault: assert property (p_fault) else $error("fault result");
endmodule

bind pqpc_top pqpc_top_sva pqpc_top_sva_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .req_valid_i(req_valid_i), .req_code_i(req_code_i), .rsp_valid_o(rsp_valid_o),
  .rsp_code_o(rsp_code_o), .rsp_result_o(rsp_result_o), .rsp_data_o(rsp_data_o),
  .noise_level_i(noise_level_i), .tx_busy_i(tx_busy_i), .core_fault_i(core_fault_i),
  .rx_enable_o(rx_enable_o), .tx_enable_o(tx_enable_o), .flush_o(flush_o));

// ===== dv/test_phy_query_and_power_control.sv
`include "pqpc_map.svh"

module test_phy_query_and_power_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i, rst_n_i, req_valid_i, rsp_valid_o, frame_done_i, mains_cross_i;
  logic        tx_busy_i, core_fault_i, rx_enable_o, tx_enable_o, flush_o;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [2:0]  req_code_i, rsp_code_o;
  logic [1:0]  rsp_result_o, r;
  logic [19:0] rsp_data_o, d;
  logic [7:0]  noise_level_i, frame_signal_i, frame_noise_i;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0]  lv [6] = '{8'h32, 8'h33, 8'h35, 8'h36, 8'h5C, 8'h5D};
  logic [3:0]  lx [6] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'hE, 4'hF};
  logic [7:0]  sv [6] = '{8'h3C, 8'h3D, 8'h42, 8'h4E, 8'h32, 8'h4F};
  logic [2:0]  sx [6] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h0, 3'h7};
  int          n_mismatch = 0;
  int          checked = 0;
  int          cyc = 0;

  pqpc_top pqpc_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_code_i(req_code_i), .rsp_valid_o(rsp_valid_o), .rsp_code_o(rsp_code_o),
    .rsp_result_o(rsp_result_o), .rsp_data_o(rsp_data_o), .noise_level_i(noise_level_i),
    .frame_done_i(frame_done_i), .frame_signal_i(frame_signal_i),
    .frame_noise_i(frame_noise_i), .mains_cross_i(mains_cross_i), .tx_busy_i(tx_busy_i),
    .core_fault_i(core_fault_i), .rx_enable_o(rx_enable_o), .tx_enable_o(tx_enable_o),
    .flush_o(flush_o), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  pqpc_mac_model pqpc_mac_model_i (.clk_i(clk_i), .req_valid_o(req_valid_i),
    .req_code_o(req_code_i), .rsp_valid_i(rsp_valid_o), .rsp_result_i(rsp_result_o),
    .rsp_data_i(rsp_data_o));

  // Clock and hang guard
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= wd;
    do
    begin
      @(posedge clk_i);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic ask(input logic [2:0] c, input logic [1:0] er, input logic [19:0] ed);
    pqpc_mac_model_i.send(c, r, d);
    chk({18'h0, r}, {18'h0, er});
    chk(d, ed);
  endtask

  task automatic en(input logic [1:0] e);
    @(negedge clk_i);
    chk({18'h0, rx_enable_o, tx_enable_o}, {18'h0, e});
    @(posedge clk_i);
  endtask

  task automatic report_and_stop();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    clk_i = 1'b0; rst_n_i = 1'b0; noise_level_i = 8'h00; frame_done_i = 1'b0;
    frame_signal_i = 8'h00; frame_noise_i = 8'h3C; mains_cross_i = 1'b0;
    tx_busy_i = 1'b0; core_fault_i = 1'b0; avs_address = 4'h0; avs_read = 1'b0;
    avs_write = 1'b0; avs_writedata = 32'h0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    bus(1'b0, `PQPC_REG_CTRL, 32'h0);
    chk(q[19:0], 20'h1);
    bus(1'b0, 4'h2, 32'h0);
    chk(q[19:0], 20'h0);
    for (int i = 0; i < 6; i++)
    begin
      noise_level_i <= lv[i];
      @(posedge clk_i);
      ask(`PQPC_CMD_FLOOR, 2'h0, {16'h0, lx[i]});
    end
    for (int i = 0; i < 6; i++)
    begin
      frame_signal_i <= sv[i];
      frame_done_i <= 1'b1;
      @(posedge clk_i);
      frame_done_i <= 1'b0;
      ask(`PQPC_CMD_QUALITY, 2'h0, {17'h0, sx[i]});
    end
    ask(`PQPC_CMD_QUALITY, 2'h0, 20'h7);
    ask(3'h7, 2'h1, 20'h0);
    $display("test queries done");
    while (cyc < 1000) @(posedge clk_i);
    mains_cross_i <= 1'b1;
    @(posedge clk_i);
    mains_cross_i <= 1'b0;
    repeat (400) @(posedge clk_i);
    ask(`PQPC_CMD_CROSSING, 2'h0, 20'h2);
    bus(1'b0, `PQPC_REG_CROSS, 32'h0);
    chk(q[19:0], 20'h2);
    tx_busy_i <= 1'b1;
    fork
      ask(`PQPC_CMD_SUSPEND, 2'h0, 20'h0);
      begin
        repeat (6) @(posedge clk_i);
        tx_busy_i <= 1'b0;
      end
    join
    en(2'b00);
    bus(1'b0, `PQPC_REG_STATUS, 32'h0);
    chk(q[19:0], 20'h003FA);
    ask(`PQPC_CMD_SUSPEND, 2'h2, 20'h0);
    ask(`PQPC_CMD_WAKE, 2'h0, 20'h0);
    en(2'b11);
    ask(`PQPC_CMD_WAKE, 2'h2, 20'h0);
    ask(`PQPC_CMD_REINIT, 2'h0, 20'h0);
    ask(`PQPC_CMD_QUALITY, 2'h0, 20'h0);
    core_fault_i <= 1'b1;
    ask(`PQPC_CMD_REINIT, 2'h1, 20'h0);
    core_fault_i <= 1'b0;
    bus(1'b1, `PQPC_REG_CTRL, 32'h0);
    ask(`PQPC_CMD_SUSPEND, 2'h1, 20'h0);
    bus(1'b1, `PQPC_REG_CTRL, 32'h1);
    bus(1'b0, `PQPC_REG_CTRL, 32'h0);
    chk(q[19:0], 20'h1);
    $display("test management done");
    report_and_stop();
  end
endmodule
